// File: fci_host.sv
// Host controller driving the flash command interface pins
`default_nettype none
`include "fci_cfg.svh"

module fci_host #(
  parameter int POLL_LIMIT = `FCI_POLL_LIMIT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire fci_pkg::fci_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output fci_pkg::fci_rsp_t rsp,
  input wire logic byte_mode,
  input wire logic pd_req,
  input wire logic supply_ok,
  output logic program_supply_en,
  output logic boot_unlock_en,
  output logic id_voltage_en,
  output logic chip_enable_n,
  output logic output_enable_n,
  output logic write_enable_n,
  output logic power_down_n,
  output logic byte_n,
  output logic [`FCI_ADDR_W-1:0] addr,
  input wire logic [`FCI_DQ_W-1:0] dq_i,
  output logic [`FCI_DQ_W-1:0] dq_o,
  output logic [`FCI_DQ_W-1:0] dq_oe
);

  localparam logic [31:0] RD_WAIT = 32'(`FCI_RD_CYC + `FCI_SYNC_CYC - 1);
  localparam logic [31:0] WP_WAIT = 32'(`FCI_WP_CYC - 1);
  localparam logic [31:0] POLL_MAX = 32'(POLL_LIMIT);

  typedef enum logic [2:0] {
    S_IDLE,
    S_STEP,
    S_WSET,
    S_WPUL,
    S_WEND,
    S_RWAIT,
    S_GAP
  } fci_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin input synchronisers

  logic [`FCI_DQ_W-1:0] dq_s;
  logic supply_ok_s;

  fci_sync #(
    .W(`FCI_DQ_W + 1)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d({supply_ok, dq_i}),
    .q({supply_ok_s, dq_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Step table per operation

  function automatic fci_pkg::fci_step_t step_of(fci_pkg::fci_op_t op,
                                                 logic [1:0] st);
    fci_pkg::fci_step_t s;
    s = '{act: fci_pkg::FCI_ACT_END, cmd: 8'h00, use_data: 1'b0};
    case (op)
      fci_pkg::FCI_OP_ARRAY: begin
        if (st == 2'h0) s = '{fci_pkg::FCI_ACT_WR, `FCI_CMD_READ_ARRAY, 1'b0};
        if (st == 2'h1) s.act = fci_pkg::FCI_ACT_RD;
      end
      fci_pkg::FCI_OP_STATUS: begin
        if (st == 2'h0) s = '{fci_pkg::FCI_ACT_WR, `FCI_CMD_READ_STATUS, 1'b0};
        if (st == 2'h1) s.act = fci_pkg::FCI_ACT_RD;
      end
      fci_pkg::FCI_OP_CLEAR: begin
        if (st == 2'h0) s = '{fci_pkg::FCI_ACT_WR, `FCI_CMD_CLEAR_STATUS, 1'b0};
      end
      fci_pkg::FCI_OP_ID: begin
        if (st == 2'h0) s = '{fci_pkg::FCI_ACT_WR, `FCI_CMD_READ_ID, 1'b0};
        if (st == 2'h1) s.act = fci_pkg::FCI_ACT_RD;
        if (st == 2'h2) s = '{fci_pkg::FCI_ACT_WR, `FCI_CMD_READ_ARRAY, 1'b0};
      end
      fci_pkg::FCI_OP_ID_HV: begin
        if (st == 2'h0) s.act = fci_pkg::FCI_ACT_RD;
      end
      fci_pkg::FCI_OP_PROG: begin
        if (st == 2'h0) s = '{fci_pkg::FCI_ACT_WR, `FCI_CMD_PROG_SETUP, 1'b0};
        if (st == 2'h1) s = '{fci_pkg::FCI_ACT_WR, 8'h00, 1'b1};
        if (st == 2'h2) s.act = fci_pkg::FCI_ACT_POLL;
      end
      fci_pkg::FCI_OP_ERASE: begin
        if (st == 2'h0) s = '{fci_pkg::FCI_ACT_WR, `FCI_CMD_ERASE_SETUP, 1'b0};
        if (st == 2'h1) s = '{fci_pkg::FCI_ACT_WR, `FCI_CMD_CONFIRM, 1'b0};
        if (st == 2'h2) s.act = fci_pkg::FCI_ACT_POLL;
      end
      fci_pkg::FCI_OP_SUSPEND: begin
        if (st == 2'h0) s = '{fci_pkg::FCI_ACT_WR, `FCI_CMD_SUSPEND, 1'b0};
        if (st == 2'h1) s.act = fci_pkg::FCI_ACT_POLL;
      end
      fci_pkg::FCI_OP_RESUME: begin
        if (st == 2'h0) s = '{fci_pkg::FCI_ACT_WR, `FCI_CMD_CONFIRM, 1'b0};
      end
      default: s.act = fci_pkg::FCI_ACT_END;
    endcase
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  fci_state_t state_r, state_nxt;
  logic [1:0] step_r, step_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [31:0] tmo_r, tmo_nxt;
  logic suspended_r, suspended_nxt;
  fci_pkg::fci_req_t req_r, req_nxt;
  fci_pkg::fci_rsp_t rsp_r, rsp_nxt;
  logic ready_r, ready_nxt, done_r, done_nxt;
  logic vpp_r, vpp_nxt, boot_r, boot_nxt, a9_r, a9_nxt;
  logic ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt;
  logic pwd_n_r, pwd_n_nxt, byte_n_r;
  logic [`FCI_ADDR_W-1:0] addr_r, addr_nxt;
  logic [`FCI_DQ_W-1:0] dq_o_r, dq_o_nxt, dq_oe_r, dq_oe_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding

  fci_pkg::fci_step_t cur;
  logic is_alter, read_only_op, refuse, is_id;
  logic [`FCI_DQ_W-1:0] rd_data, wr_word, oe_wr, oe_rd;
  logic [`FCI_ADDR_W-1:0] step_addr;
  logic poll_ready, poll_out, alt_bit;

  assign cur = step_of(req_r.op, step_r);
  assign is_alter = (req.op == fci_pkg::FCI_OP_PROG) ||
                    (req.op == fci_pkg::FCI_OP_ERASE);
  assign read_only_op = (req.op == fci_pkg::FCI_OP_ARRAY) ||
                        (req.op == fci_pkg::FCI_OP_STATUS) ||
                        (req.op == fci_pkg::FCI_OP_RESUME);
  assign refuse = (is_alter && !supply_ok_s) ||
                  (suspended_r && !read_only_op);
  assign is_id = (req_r.op == fci_pkg::FCI_OP_ID) ||
                 (req_r.op == fci_pkg::FCI_OP_ID_HV);
  assign rd_data = byte_mode ? {8'h00, dq_s[7:0]} : dq_s;
  assign step_addr = (is_id && cur.act != fci_pkg::FCI_ACT_WR) ?
                     {{(`FCI_ADDR_W-1){1'b0}}, req_r.addr[0]} : req_r.addr;
  assign alt_bit = byte_mode && !is_id && req_r.a_m1;
  assign wr_word = cur.use_data ? req_r.data : {8'h00, cur.cmd};
  assign oe_wr = byte_mode ? `FCI_OE_WR_BYTE : `FCI_OE_WR_WORD;
  assign oe_rd = byte_mode ? `FCI_OE_RD_BYTE : `FCI_OE_RD_WORD;
  assign poll_ready = dq_s[`FCI_ST_READY_BIT];
  assign poll_out = (tmo_r >= POLL_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_nxt = state_r;
    step_nxt = step_r;
    cnt_nxt = cnt_r;
    tmo_nxt = tmo_r;
    suspended_nxt = suspended_r;
    req_nxt = req_r;
    rsp_nxt = rsp_r;
    done_nxt = 1'b0;
    ready_nxt = 1'b0;
    vpp_nxt = vpp_r;
    boot_nxt = boot_r;
    a9_nxt = a9_r;
    ce_n_nxt = ce_n_r;
    oe_n_nxt = oe_n_r;
    we_n_nxt = we_n_r;
    pwd_n_nxt = pwd_n_r;
    addr_nxt = addr_r;
    dq_o_nxt = dq_o_r;
    dq_oe_nxt = dq_oe_r;
    case (state_r)
      S_IDLE: begin
        pwd_n_nxt = !pd_req;
        ready_nxt = !pd_req && pwd_n_r && !(req_valid && ready_r);
        if (req_valid && ready_r) begin
          req_nxt = req;
          step_nxt = 2'h0;
          tmo_nxt = 32'h0;
          rsp_nxt = '0;
          if (refuse) begin
            rsp_nxt.refused = 1'b1;
            done_nxt = 1'b1;
            ready_nxt = 1'b1;
          end else begin
            vpp_nxt = is_alter;
            boot_nxt = req.boot;
            a9_nxt = (req.op == fci_pkg::FCI_OP_ID_HV);
            state_nxt = S_STEP;
          end
        end
      end
      S_STEP: begin
        addr_nxt = step_addr;
        case (cur.act)
          fci_pkg::FCI_ACT_WR: begin
            ce_n_nxt = 1'b0;
            oe_n_nxt = 1'b1;
            dq_o_nxt = wr_word;
            dq_o_nxt[`FCI_ALT_ADDR_BIT] = byte_mode ? alt_bit :
                                          wr_word[`FCI_ALT_ADDR_BIT];
            dq_oe_nxt = oe_wr;
            state_nxt = S_WSET;
          end
          fci_pkg::FCI_ACT_RD, fci_pkg::FCI_ACT_POLL: begin
            ce_n_nxt = 1'b0;
            oe_n_nxt = 1'b0;
            we_n_nxt = 1'b1;
            dq_o_nxt = {alt_bit, {(`FCI_DQ_W-1){1'b0}}};
            dq_oe_nxt = oe_rd;
            cnt_nxt = RD_WAIT;
            state_nxt = S_RWAIT;
          end
          default: begin
            rsp_nxt.fail = vpp_r && (rsp_r.status[`FCI_ST_PROG_ERR_BIT] ||
                           rsp_r.status[`FCI_ST_ERASE_ERR_BIT] ||
                           rsp_r.status[`FCI_ST_SUPPLY_ERR_BIT]);
            if (req_r.op == fci_pkg::FCI_OP_SUSPEND && !rsp_r.timeout) begin
              suspended_nxt = 1'b1;
            end
            if (req_r.op == fci_pkg::FCI_OP_RESUME) begin
              suspended_nxt = 1'b0;
            end
            vpp_nxt = 1'b0;
            boot_nxt = 1'b0;
            a9_nxt = 1'b0;
            done_nxt = 1'b1;
            ready_nxt = !pd_req;
            state_nxt = S_IDLE;
          end
        endcase
      end
      S_WSET: begin
        we_n_nxt = 1'b0;
        cnt_nxt = WP_WAIT;
        state_nxt = S_WPUL;
      end
      S_WPUL: begin
        if (cnt_r == 32'h0) begin
          we_n_nxt = 1'b1;
          state_nxt = S_WEND;
        end else begin
          cnt_nxt = cnt_r - 32'h1;
        end
      end
      S_WEND: begin
        ce_n_nxt = 1'b1;
        step_nxt = step_r + 2'h1;
        state_nxt = S_GAP;
      end
      S_RWAIT: begin
        if (cnt_r == 32'h0) begin
          ce_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          state_nxt = S_GAP;
          if (cur.act == fci_pkg::FCI_ACT_POLL) begin
            rsp_nxt.status = dq_s[7:0];
            tmo_nxt = tmo_r + 32'h1;
            if (poll_ready) begin
              step_nxt = step_r + 2'h1;
            end else if (poll_out) begin
              rsp_nxt.timeout = 1'b1;
              step_nxt = step_r + 2'h1;
            end
          end else begin
            rsp_nxt.data = rd_data;
            rsp_nxt.status = dq_s[7:0];
            step_nxt = step_r + 2'h1;
          end
        end else begin
          cnt_nxt = cnt_r - 32'h1;
        end
      end
      S_GAP: begin
        dq_oe_nxt = byte_mode ? `FCI_OE_RD_BYTE : `FCI_OE_RD_WORD;
        state_nxt = S_STEP;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_r <= S_IDLE;
      step_r <= 2'h0;
      cnt_r <= 32'h0;
      tmo_r <= 32'h0;
      suspended_r <= 1'b0;
      req_r <= '0;
      rsp_r <= '0;
      ready_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      cnt_r <= cnt_nxt;
      tmo_r <= tmo_nxt;
      suspended_r <= suspended_nxt;
      req_r <= req_nxt;
      rsp_r <= rsp_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vpp_r <= 1'b0;
      boot_r <= 1'b0;
      a9_r <= 1'b0;
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      pwd_n_r <= 1'b0;
      byte_n_r <= 1'b1;
      addr_r <= `FCI_RST_ADDR;
      dq_o_r <= `FCI_RST_DATA;
      dq_oe_r <= `FCI_OE_RD_WORD;
    end else begin
      vpp_r <= vpp_nxt;
      boot_r <= boot_nxt;
      a9_r <= a9_nxt;
      ce_n_r <= ce_n_nxt;
      oe_n_r <= oe_n_nxt;
      we_n_r <= we_n_nxt;
      pwd_n_r <= pwd_n_nxt;
      byte_n_r <= !byte_mode;
      addr_r <= addr_nxt;
      dq_o_r <= dq_o_nxt;
      dq_oe_r <= dq_oe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign req_ready = ready_r;
  assign rsp_valid = done_r;
  assign rsp = rsp_r;
  assign program_supply_en = vpp_r;
  assign boot_unlock_en = boot_r;
  assign id_voltage_en = a9_r;
  assign chip_enable_n = ce_n_r;
  assign output_enable_n = oe_n_r;
  assign write_enable_n = we_n_r;
  assign power_down_n = pwd_n_r;
  assign byte_n = byte_n_r;
  assign addr = addr_r;
  assign dq_o = dq_o_r;
  assign dq_oe = dq_oe_r;

endmodule

`default_nettype wire

// File: fci_cfg.svh
// Constants for the flash command interface host controller
`ifndef FCI_CFG_SVH
`define FCI_CFG_SVH

////////////////////////////////////////////////////////////////////////////
// Command codes
`define FCI_CMD_READ_ARRAY 8'hff
`define FCI_CMD_READ_ID 8'h90
`define FCI_CMD_READ_STATUS 8'h70
`define FCI_CMD_CLEAR_STATUS 8'h50
`define FCI_CMD_PROG_SETUP 8'h40
`define FCI_CMD_ERASE_SETUP 8'h20
`define FCI_CMD_CONFIRM 8'hd0
`define FCI_CMD_SUSPEND 8'hb0

////////////////////////////////////////////////////////////////////////////
// Status register fields
`define FCI_ST_READY_BIT 7
`define FCI_ST_ERASE_ERR_BIT 5
`define FCI_ST_PROG_ERR_BIT 4
`define FCI_ST_SUPPLY_ERR_BIT 3

////////////////////////////////////////////////////////////////////////////
// Pin layout and reset values
`define FCI_ADDR_W 17
`define FCI_DQ_W 16
`define FCI_ALT_ADDR_BIT 15
`define FCI_OE_WR_WORD 16'hffff
`define FCI_OE_WR_BYTE 16'h80ff
`define FCI_OE_RD_WORD 16'h0000
`define FCI_OE_RD_BYTE 16'h8000
`define FCI_RST_ADDR 17'h00000
`define FCI_RST_DATA 16'h0000

////////////////////////////////////////////////////////////////////////////
// Timing
`define FCI_CLK_NS 100
`define FCI_T_ACC_NS 120
`define FCI_T_WP_NS 50
`define FCI_RD_CYC ((`FCI_T_ACC_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_WP_CYC ((`FCI_T_WP_NS + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_SYNC_CYC 2
`define FCI_POLL_LIMIT 1000000

`endif

// File: fci_pkg.sv
// Types for the flash command interface host controller
`default_nettype none
`include "fci_cfg.svh"

package fci_pkg;

  typedef enum logic [3:0] {
    FCI_OP_ARRAY,
    FCI_OP_STATUS,
    FCI_OP_CLEAR,
    FCI_OP_ID,
    FCI_OP_ID_HV,
    FCI_OP_PROG,
    FCI_OP_ERASE,
    FCI_OP_SUSPEND,
    FCI_OP_RESUME
  } fci_op_t;

  typedef enum logic [1:0] {
    FCI_ACT_WR,
    FCI_ACT_RD,
    FCI_ACT_POLL,
    FCI_ACT_END
  } fci_act_t;

  typedef struct packed {
    fci_act_t act;
    logic [7:0] cmd;
    logic use_data;
  } fci_step_t;

  typedef struct packed {
    fci_op_t op;
    logic [`FCI_ADDR_W-1:0] addr;
    logic a_m1;
    logic [`FCI_DQ_W-1:0] data;
    logic boot;
  } fci_req_t;

  typedef struct packed {
    logic [`FCI_DQ_W-1:0] data;
    logic [7:0] status;
    logic refused;
    logic timeout;
    logic fail;
  } fci_rsp_t;

endpackage

`default_nettype wire

// File: fci_sync.sv
// Two-stage synchroniser for pin inputs
`default_nettype none

module fci_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

`default_nettype wire

// File: fci_dev_model.sv
// Behavioural flash device answering the host controller pins
`default_nettype none
`include "fci_cfg.svh"

module fci_dev_model #(
  parameter logic [15:0] MFR_CODE = 16'h00a5, // Arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h5a3c, // Arbitrary value
  parameter logic [16:0] BOOT_TOP = 17'h01fff,
  parameter int PROG_CYC = 6,
  parameter int ERASE_CYC = 300
) (
  input wire logic sys_clk,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic pd_n,
  input wire logic byte_n,
  input wire logic supply,
  input wire logic unlock,
  input wire logic id_hv,
  input wire logic [`FCI_ADDR_W-1:0] addr,
  input wire logic [`FCI_DQ_W-1:0] dq_in,
  output logic [`FCI_DQ_W-1:0] dq_out
);
  typedef enum logic [1:0] {FCI_M_ARR, FCI_M_ID, FCI_M_ST} fci_mode_t;
  fci_mode_t mode = FCI_M_ARR;
  logic [15:0] mem [16];
  logic [15:0] pdata, word;
  logic [7:0] st = 8'h80, lo;
  logic [3:0] pidx;
  logic pset = 0, eset = 0, bprog = 0, berase = 0, susp = 0;
  logic we_q = 1, flt = 0;
  int cnt = 0;
  wire [7:0] c = dq_in[7:0];
  wire wr_done = we_n && !we_q && !ce_n && oe_n && pd_n;
  wire locked = (addr <= BOOT_TOP) && !unlock;
  wire drive = !ce_n && !oe_n && we_n && pd_n;

  initial foreach (mem[i]) mem[i] = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Command decoder and sequencer
  always @(posedge sys_clk) begin
    we_q <= we_n;
    flt <= ~flt;
    if (!pd_n) begin
      mode <= FCI_M_ARR;
      {pset, eset, bprog, berase, susp} <= '0;
      st <= 8'h80;
    end else begin
      if ((bprog || berase) && !susp) begin
        cnt <= cnt - 1;
        if (cnt == 1) begin
          {bprog, berase} <= 2'b00;
          st[7] <= 1'b1;
          if (bprog) mem[pidx] <= pdata;
          else for (int i = 0; i < 16; i++) mem[i] <= 16'hffff;
        end
      end
      if (wr_done) begin
        if (bprog) begin
          if (c == 8'h70) mode <= FCI_M_ST;
        end else if (berase && !susp) begin
          if (c == 8'h70) mode <= FCI_M_ST;
          else if (c == 8'hb0) {susp, st[7]} <= 2'b11;
        end else if (susp) begin
          if (c == 8'hff) mode <= FCI_M_ARR;
          else if (c == 8'h70) mode <= FCI_M_ST;
          else if (c == 8'hd0) begin
            {susp, st[7]} <= 2'b00;
            mode <= FCI_M_ST;
          end
        end else if (pset) begin
          pset <= 1'b0;
          mode <= FCI_M_ST;
          if (!supply) st[3] <= 1'b1;
          else if (locked) st[4] <= 1'b1;
          else begin
            {bprog, st[7], cnt} <= {2'b10, PROG_CYC};
            pdata <= dq_in;
            pidx <= addr[3:0];
          end
        end else if (eset) begin
          eset <= 1'b0;
          if (c != 8'hd0) begin
            st[5:4] <= 2'b11;
            mode <= FCI_M_ARR;
          end else begin
            mode <= FCI_M_ST;
            if (!supply) st[3] <= 1'b1;
            else if (locked) st[5] <= 1'b1;
            else {berase, st[7], cnt} <= {2'b10, ERASE_CYC};
          end
        end else begin
          case (c)
            8'hff: mode <= FCI_M_ARR;
            8'h90: mode <= FCI_M_ID;
            8'h70: mode <= FCI_M_ST;
            8'h50: st[5:3] <= 3'b000;
            8'h40, 8'h10: pset <= 1'b1;
            8'h20: eset <= 1'b1;
            default: ;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output path, pins float as a toggling pattern when released
  always_comb begin
    if (id_hv || mode == FCI_M_ID) word = addr[0] ? DEV_CODE : MFR_CODE;
    else if (mode == FCI_M_ST) word = {8'h00, st};
    else word = mem[addr[3:0]];
    lo = (dq_in[15] && mode == FCI_M_ARR && !id_hv) ? word[15:8] : word[7:0];
    if (!drive) dq_out = {16{flt}};
    else if (byte_n) dq_out = word;
    else dq_out = {{8{flt}}, lo};
  end
endmodule

`default_nettype wire

// File: fci_host_asserts.sv
// Pin protocol checker for the flash host controller
`default_nettype none
`include "fci_cfg.svh"

module fci_host_chk #(
  parameter int POLL_LIMIT = `FCI_POLL_LIMIT
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire fci_pkg::fci_req_t req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire fci_pkg::fci_rsp_t rsp,
  input wire logic pd_req,
  input wire logic supply_ok,
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic power_down_n,
  input wire logic byte_n,
  input wire logic [`FCI_ADDR_W-1:0] addr,
  input wire logic [`FCI_DQ_W-1:0] dq_o,
  input wire logic [`FCI_DQ_W-1:0] dq_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire prog_like = req.op == fci_pkg::FCI_OP_PROG ||
    req.op == fci_pkg::FCI_OP_ERASE;

  wr_cycle_a: assert property (!write_enable_n |-> !chip_enable_n &&
    output_enable_n && power_down_n) else $error("bad write cycle");
  rd_cycle_a: assert property (!output_enable_n |-> !chip_enable_n &&
    write_enable_n && power_down_n) else $error("bad read cycle");
  rd_float_a: assert property (!output_enable_n |->
    dq_oe[14:0] == 15'h0000) else $error("host drives during read");
  wr_drive_a: assert property (!write_enable_n |->
    dq_oe[7:0] == 8'hff) else $error("write data not driven");
  we_pulse_a: assert property ($fell(write_enable_n) |=> write_enable_n &&
    $stable(dq_o) && $stable(addr)) else $error("write pulse wrong");
  pd_reset_a: assert property (disable iff (1'b0) !rst_n |=>
    !power_down_n && chip_enable_n) else $error("no power-down in reset");
  pd_quiet_a: assert property (!power_down_n |-> chip_enable_n &&
    output_enable_n && write_enable_n) else $error("cycle in power-down");
  supply_refuse_a: assert property (req_valid && req_ready && prog_like &&
    !supply_ok && !$past(supply_ok) && !$past(supply_ok, 2) &&
    !$past(supply_ok, 3) |=> rsp_valid && rsp.refused && chip_enable_n)
    else $error("op without supply not refused");
  rd_hold_a: assert property ($fell(output_enable_n) |=>
    (!output_enable_n && $stable(addr))[*3]) else $error("read too short");
  byte_pin_a: assert property (!byte_n && !output_enable_n |->
    dq_oe == 16'h8000) else $error("byte read pin drive wrong");
  pd_ready_a: assert property (pd_req && $past(pd_req) |->
    !req_ready) else $error("ready during power-down");

  cover property (rsp_valid && rsp.refused);
  cover property (rsp_valid && rsp.timeout);
  cover property (!byte_n && !output_enable_n);
  cover property (pd_req && !power_down_n);
endmodule

bind fci_host fci_host_chk #(.POLL_LIMIT(POLL_LIMIT)) u_fci_host_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
  .pd_req(pd_req), .supply_ok(supply_ok), .chip_enable_n(chip_enable_n),
  .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
  .power_down_n(power_down_n), .byte_n(byte_n), .addr(addr),
  .dq_o(dq_o), .dq_oe(dq_oe));

`default_nettype wire

// File: tb.sv
// Self-checking bench for the flash host controller
`default_nettype none
`include "fci_cfg.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  miscompares++; $display("Error %0t: got %h exp %h", $time, a, e); end end

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] MFR = 16'h00a5;
  localparam logic [15:0] DEV = 16'h5a3c;
  logic sys_clk = 1'b0, rst_n, req_valid, req_ready, rsp_valid, byte_mode;
  logic pd_req, supply_ok, psup_en, unlock_en, idv_en, ce_n, oe_n, we_n;
  logic pd_n, byte_n;
  fci_pkg::fci_req_t req;
  fci_pkg::fci_rsp_t rsp, r;
  logic [`FCI_ADDR_W-1:0] addr;
  logic [`FCI_DQ_W-1:0] dq_o, dq_oe, dev_dq;
  wire [`FCI_DQ_W-1:0] dq_i = (dq_oe & dq_o) | (~dq_oe & dev_dq);
  int miscompares = 0, samples_checked = 0, cyc = 0;
  logic unlock_seen = 1'b0, idv_seen = 1'b0;

  always @(negedge sys_clk) begin
    if (unlock_en === 1'b1) unlock_seen = 1'b1;
    if (idv_en === 1'b1) idv_seen = 1'b1;
  end

  always #50 sys_clk = ~sys_clk;

  fci_host #(.POLL_LIMIT(8)) u_fci_host (.sys_clk(sys_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp(rsp), .byte_mode(byte_mode),
    .pd_req(pd_req), .supply_ok(supply_ok), .program_supply_en(psup_en),
    .boot_unlock_en(unlock_en), .id_voltage_en(idv_en),
    .chip_enable_n(ce_n), .output_enable_n(oe_n), .write_enable_n(we_n),
    .power_down_n(pd_n), .byte_n(byte_n), .addr(addr), .dq_i(dq_i),
    .dq_o(dq_o), .dq_oe(dq_oe));

  fci_dev_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_fci_dev_model (
    .sys_clk(sys_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .pd_n(pd_n),
    .byte_n(byte_n), .supply(psup_en), .unlock(unlock_en), .id_hv(idv_en),
    .addr(addr), .dq_in(dq_i), .dq_out(dev_dq));

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      $display("Error %0t: run too long", $time);
      final_report;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One request through the user port
  task automatic run_op(input fci_pkg::fci_op_t op, input logic [16:0] a,
                        input logic [15:0] d, input logic b);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (req_ready !== 1'b1 && n < 2000) begin
      @(negedge sys_clk);
      n++;
    end
    req = '{op: op, addr: a, a_m1: 1'b0, data: d, boot: b};
    req_valid = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    r = rsp;
    `CHK(rsp_valid, 1'b1)
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_ident;
    run_op(fci_pkg::FCI_OP_ID, 17'h00000, 16'h0000, 1'b0);
    `CHK(r.data, MFR)
    run_op(fci_pkg::FCI_OP_ID, 17'h00001, 16'h0000, 1'b0);
    `CHK(r.data, DEV)
    `CHK(idv_seen, 1'b0)
    run_op(fci_pkg::FCI_OP_ID_HV, 17'h00001, 16'h0000, 1'b0);
    `CHK(r.data, DEV)
    `CHK({idv_seen, idv_en}, 2'b10)
    byte_mode = 1'b1;
    run_op(fci_pkg::FCI_OP_ID, 17'h00001, 16'h0000, 1'b0);
    `CHK(r.data, {8'h00, DEV[7:0]})
    byte_mode = 1'b0;
    $display("test ident done");
  endtask

  task automatic t_program;
    run_op(fci_pkg::FCI_OP_PROG, 17'h04003, 16'hc3a5, 1'b0);
    `CHK({r.fail, r.timeout, r.status[7]}, 3'b001)
    `CHK(psup_en, 1'b0)
    run_op(fci_pkg::FCI_OP_STATUS, 17'h04003, 16'h0000, 1'b0);
    `CHK(r.data, 16'h0080)
    run_op(fci_pkg::FCI_OP_ARRAY, 17'h04003, 16'h0000, 1'b0);
    `CHK(r.data, 16'hc3a5)
    $display("test program done");
  endtask

  task automatic t_boot;
    run_op(fci_pkg::FCI_OP_PROG, 17'h00002, 16'h5aa5, 1'b0);
    `CHK({r.fail, r.status[4]}, 2'b11)
    `CHK(unlock_seen, 1'b0)
    run_op(fci_pkg::FCI_OP_CLEAR, 17'h00000, 16'h0000, 1'b0);
    run_op(fci_pkg::FCI_OP_STATUS, 17'h00000, 16'h0000, 1'b0);
    `CHK(r.data, 16'h0080)
    run_op(fci_pkg::FCI_OP_PROG, 17'h00002, 16'h5aa5, 1'b1);
    `CHK(r.fail, 1'b0)
    `CHK({unlock_seen, unlock_en}, 2'b10)
    run_op(fci_pkg::FCI_OP_ARRAY, 17'h00002, 16'h0000, 1'b0);
    `CHK(r.data, 16'h5aa5)
    $display("test boot done");
  endtask

  task automatic t_supply;
    supply_ok = 1'b0;
    repeat (4) @(negedge sys_clk);
    run_op(fci_pkg::FCI_OP_PROG, 17'h04001, 16'h1234, 1'b0);
    `CHK(r.refused, 1'b1)
    run_op(fci_pkg::FCI_OP_ERASE, 17'h04001, 16'h0000, 1'b0);
    `CHK(r.refused, 1'b1)
    supply_ok = 1'b1;
    repeat (4) @(negedge sys_clk);
    $display("test supply done");
  endtask

  task automatic t_erase;
    int n;
    run_op(fci_pkg::FCI_OP_ERASE, 17'h04000, 16'h0000, 1'b0);
    `CHK(r.timeout, 1'b1)
    run_op(fci_pkg::FCI_OP_SUSPEND, 17'h00000, 16'h0000, 1'b0);
    `CHK(r.status[7], 1'b1)
    run_op(fci_pkg::FCI_OP_ARRAY, 17'h04003, 16'h0000, 1'b0);
    `CHK(r.data, 16'hc3a5)
    run_op(fci_pkg::FCI_OP_CLEAR, 17'h00000, 16'h0000, 1'b0);
    `CHK(r.refused, 1'b1)
    run_op(fci_pkg::FCI_OP_RESUME, 17'h00000, 16'h0000, 1'b0);
    run_op(fci_pkg::FCI_OP_ARRAY, 17'h04003, 16'h0000, 1'b0);
    `CHK(r.data, 16'h0000)
    n = 0;
    do begin
      run_op(fci_pkg::FCI_OP_STATUS, 17'h00000, 16'h0000, 1'b0);
      n++;
    end while (r.data[7] !== 1'b1 && n < 40);
    `CHK(r.data, 16'h0080)
    run_op(fci_pkg::FCI_OP_ARRAY, 17'h04003, 16'h0000, 1'b0);
    `CHK(r.data, 16'hffff)
    $display("test erase done");
  endtask

  task automatic t_powerdown;
    @(negedge sys_clk);
    pd_req = 1'b1;
    repeat (6) @(negedge sys_clk);
    `CHK(pd_n, 1'b0)
    `CHK(req_ready, 1'b0)
    pd_req = 1'b0;
    run_op(fci_pkg::FCI_OP_ID, 17'h00000, 16'h0000, 1'b0);
    `CHK(r.data, MFR)
    $display("test powerdown done");
  endtask

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    byte_mode = 1'b0;
    pd_req = 1'b0;
    supply_ok = 1'b1;
    repeat (8) @(negedge sys_clk);
    rst_n = 1'b1;
    t_ident;
    t_program;
    t_boot;
    t_supply;
    t_erase;
    t_powerdown;
    final_report;
  end
endmodule

`default_nettype wire
